// ---- hdl/srg_pkg.sv ----
// Package: register map, field layout and reset counts for soft reset and gain load
package srg_pkg;
  localparam logic [7:0]  ADDR_SOFT_RESET   = 8'h00;
  localparam logic [7:0]  ADDR_GAIN_LOAD    = 8'h04;
  localparam logic [7:0]  ADDR_TEST_CFG     = 8'h08;
  localparam logic [7:0]  ADDR_STATUS       = 8'h0C;
  localparam logic [7:0]  ADDR_LIMITER      = 8'h10;
  localparam logic [7:0]  ADDR_ACCUM        = 8'h14;
  localparam int          TEST_NCO_CLR_BIT  = 20;
  localparam int          GAIN_HI           = 15;
  localparam int          GAIN_LO           = 5;
  localparam int          EXP_HI            = 15;
  localparam int          EXP_LO            = 12;
  localparam int          MANT_HI           = 11;
  localparam int          MANT_LO           = 5;
  localparam int          ACC_W             = 32;
  localparam int          FE_PULSE_CYC      = 1;
  localparam int          BE_PULSE_CYC      = 10;
  localparam logic [2:0]  OFIFO_RD_RST      = 3'h7;
  localparam logic [2:0]  OFIFO_WR_RST      = 3'h0;
  localparam logic [31:0] TEST_CFG_RST      = 32'h0000_0000;
  localparam logic [15:0] INTERVAL_RST      = 16'h0010;
  localparam logic [4:0]  SHIFT_RST         = 5'h0F;
  localparam logic [3:0]  WORDS_RST         = 4'h3;
  localparam logic [3:0]  SYNC_RST          = 4'h1;
  localparam logic [7:0]  SERDIV_RST        = 8'h03;

  typedef struct packed {
    logic [3:0] exponent;
    logic [7:0] mantissa;
  } srg_gain_t;

  typedef struct packed {
    logic [2:0]  ofifo_rd;
    logic [2:0]  ofifo_wr;
    logic        fifo_empty;
    logic        fifo_full;
    logic [3:0]  fifo_depth;
    logic        fifo_rd_strobe;
    logic        irq;
    logic [3:0]  snap_group;
    logic [15:0] snap_interval;
  } srg_unit_t;
endpackage

// ---- hdl/srg_pulse.sv ----
// Counted pulse generator that stretches a trigger to a fixed cycle count
`timescale 1ns/1ps
module srg_pulse #(
  parameter int WIDTH_CYC = 1
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic trig,
  output logic      pulse
);
  localparam int CW = $clog2(WIDTH_CYC + 1);
  localparam logic [CW-1:0] LOAD = CW'(WIDTH_CYC);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (trig) begin
      cnt_nxt = LOAD;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - CW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Pulse is a combinational decode of the count register, not a registered output
  assign pulse = (cnt_r != '0);
endmodule

// ---- hdl/srg_top.sv ----
// Soft reset pulse generation, per-unit reset effects and AGC gain load over APB
// Summary of operation
// RULE1 - Reset command write resets everything, data ignored; code keeps test config and gain master registers
// RULE2 - Reset initialises interpolation pulse counters
// RULE3 - Test bit 20 selects timing NCO feedback clear
// RULE4 - Discriminator pointers reset, coefficient address zeroed
// RULE5 - Coordinate converter iteration counters cleared
// RULE6 - FIFO control decoder, flags, strobes reset
// RULE7 - Output FIFO read seven, write zero
// RULE8 - Snapshot group zero, interval loaded, addresses reset
// RULE9 - Serial output four counters reloaded
// RULE10 - Front-end pulse one clock wide
// RULE11 - Back-end pulse ten clocks wide
// RULE12 - Gain load synchronous to processing clock
// RULE13 - Gain write makes one load strobe
// RULE14 - Gain bits land in accumulator MSBs
// RULE15 - Bits 15:12 exponent, 11:5 mantissa
// RULE16 - Mantissa weighting is 01.mmmmmmm
// RULE17 - Accumulator mux: limiter normally, master on load
// RULE18 - Host supplies valid low 16 data bits
// RULE19 - Pulses generated synchronously in own domain
// RULE20 - Gain word bits 4:0 ignored
`timescale 1ns/1ps
module srg_top #(
  parameter int FE_CYC = srg_pkg::FE_PULSE_CYC,
  parameter int BE_CYC = srg_pkg::BE_PULSE_CYC
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [srg_pkg::ACC_W-1:0] limiter_out,
  output logic                           fe_reset_pulse,
  output logic                           be_reset_pulse,
  output logic                           timing_nco_fb_clear,
  output logic                           gain_load_strobe,
  output logic      [srg_pkg::ACC_W-1:0] agc_accum,
  output srg_pkg::srg_gain_t             agc_gain,
  output srg_pkg::srg_unit_t             unit_state
);
  logic        wr_acc;
  logic        rd_acc;
  logic        soft_rst_wr;
  logic        gain_wr;
  logic [31:0] test_cfg_r;
  logic [31:0] test_cfg_nxt;
  logic [15:0] master_r;
  logic [15:0] master_nxt;
  logic        load_r;
  logic        load_nxt;
  logic [31:0] rdata_nxt;
  logic [31:0] prdata_r;
  logic [srg_pkg::ACC_W-1:0] acc_r;
  logic [srg_pkg::ACC_W-1:0] acc_nxt;
  srg_pkg::srg_unit_t unit_r;
  srg_pkg::srg_unit_t unit_nxt;
  logic [3:0]  interp_cnt_r;
  logic [3:0]  interp_cnt_nxt;
  logic [3:0]  disc_rd_r;
  logic [3:0]  disc_wr_r;
  logic [5:0]  disc_coef_r;
  logic [3:0]  disc_rd_nxt;
  logic [3:0]  disc_wr_nxt;
  logic [5:0]  disc_coef_nxt;
  logic [4:0]  cordic_cnt_r;
  logic [4:0]  cordic_cnt_nxt;
  logic [1:0]  fifo_dec_r;
  logic [1:0]  fifo_dec_nxt;
  logic [2:0]  snap_wr_r;
  logic [2:0]  snap_rd_r;
  logic [2:0]  snap_wr_nxt;
  logic [2:0]  snap_rd_nxt;
  logic [4:0]  ser_shift_r;
  logic [3:0]  ser_words_r;
  logic [3:0]  ser_sync_r;
  logic [7:0]  ser_div_r;
  logic [4:0]  ser_shift_nxt;
  logic [3:0]  ser_words_nxt;
  logic [3:0]  ser_sync_nxt;
  logic [7:0]  ser_div_nxt;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // Zero-wait slave: every access completes in its access phase
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & ~penable & ~pwrite;
  assign soft_rst_wr = wr_acc & hit(paddr, srg_pkg::ADDR_SOFT_RESET); // RULE1
  assign gain_wr     = wr_acc & hit(paddr, srg_pkg::ADDR_GAIN_LOAD); // RULE12

  // Both pulses are counted on ref_clk so each releases on a clean edge
  srg_pulse #(.WIDTH_CYC(FE_CYC)) u_fe (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .trig    (soft_rst_wr),
    .pulse   (fe_reset_pulse)
  ); // RULE10 RULE19
  srg_pulse #(.WIDTH_CYC(BE_CYC)) u_be (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .trig    (soft_rst_wr),
    .pulse   (be_reset_pulse)
  ); // RULE11 RULE19

  assign timing_nco_fb_clear = be_reset_pulse & test_cfg_r[srg_pkg::TEST_NCO_CLR_BIT]; // RULE3

  // Register file and gain load
  always_comb begin
    test_cfg_nxt = test_cfg_r;
    master_nxt   = master_r;
    load_nxt     = 1'b0;
    if (wr_acc && hit(paddr, srg_pkg::ADDR_TEST_CFG)) begin
      test_cfg_nxt = pwdata;
    end
    if (gain_wr) begin
      master_nxt = pwdata[15:0]; // RULE18
      load_nxt   = 1'b1; // RULE13
    end
  end

  always_comb begin
    rdata_nxt = prdata_r;
    if (rd_acc) begin
      case (paddr)
        srg_pkg::ADDR_TEST_CFG: rdata_nxt = test_cfg_r;
        srg_pkg::ADDR_STATUS:   rdata_nxt = {29'h0, timing_nco_fb_clear, be_reset_pulse, fe_reset_pulse};
        srg_pkg::ADDR_ACCUM:    rdata_nxt = acc_r;
        srg_pkg::ADDR_LIMITER:  rdata_nxt = {unit_r.ofifo_rd, unit_r.ofifo_wr, unit_r.fifo_empty,
                                             unit_r.fifo_full, unit_r.fifo_depth, unit_r.snap_group,
                                             16'h0000};
        default:                rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Accumulator mux: limiter path normally, master value on load
  always_comb begin
    acc_nxt = limiter_out; // RULE17
    if (load_r) begin
      acc_nxt = {master_r[srg_pkg::GAIN_HI:srg_pkg::GAIN_LO],
                 {(srg_pkg::ACC_W-11){1'b0}}}; // RULE14 RULE20
    end
  end

  assign gain_load_strobe = load_r;
  assign agc_accum        = acc_r;
  assign prdata           = prdata_r;
  assign agc_gain.exponent = master_r[srg_pkg::EXP_HI:srg_pkg::EXP_LO]; // RULE15
  assign agc_gain.mantissa = {1'b1, master_r[srg_pkg::MANT_HI:srg_pkg::MANT_LO]}; // RULE15 RULE16

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      test_cfg_r <= srg_pkg::TEST_CFG_RST;
      master_r   <= 16'h0000;
      load_r     <= 1'b0;
      prdata_r   <= 32'h0000_0000;
      acc_r      <= '0;
    end else begin
      test_cfg_r <= test_cfg_nxt;
      master_r   <= master_nxt;
      load_r     <= load_nxt;
      prdata_r   <= rdata_nxt;
      acc_r      <= acc_nxt;
    end
  end

  // Unit state: counters and snap_interval run freely, other unit fields hold; reinitialised while the matching pulse stands
  always_comb begin
    interp_cnt_nxt = interp_cnt_r + 4'h1;
    disc_rd_nxt    = disc_rd_r + 4'h1;
    disc_wr_nxt    = disc_wr_r + 4'h1;
    disc_coef_nxt  = disc_coef_r + 6'h01;
    cordic_cnt_nxt = cordic_cnt_r + 5'h01;
    fifo_dec_nxt   = fifo_dec_r + 2'h1;
    snap_wr_nxt    = snap_wr_r + 3'h1;
    snap_rd_nxt    = snap_rd_r + 3'h1;
    ser_shift_nxt  = ser_shift_r - 5'h01;
    ser_words_nxt  = ser_words_r - 4'h1;
    ser_sync_nxt   = ser_sync_r - 4'h1;
    ser_div_nxt    = ser_div_r - 8'h01;
    unit_nxt       = unit_r;
    unit_nxt.snap_interval = unit_r.snap_interval - 16'h0001;
    if (fe_reset_pulse) begin
      interp_cnt_nxt = 4'h0; // RULE2
    end
    if (be_reset_pulse) begin
      disc_rd_nxt    = 4'h0; // RULE4
      disc_wr_nxt    = 4'h0; // RULE4
      disc_coef_nxt  = 6'h00; // RULE4
      cordic_cnt_nxt = 5'h00; // RULE5
      fifo_dec_nxt   = 2'h0; // RULE6
      unit_nxt.fifo_rd_strobe = 1'b0; // RULE6
      unit_nxt.irq        = 1'b0; // RULE6
      unit_nxt.fifo_depth = 4'h0; // RULE6
      unit_nxt.fifo_full  = 1'b0; // RULE6
      unit_nxt.fifo_empty = 1'b1; // RULE6
      unit_nxt.ofifo_rd   = srg_pkg::OFIFO_RD_RST; // RULE7
      unit_nxt.ofifo_wr   = srg_pkg::OFIFO_WR_RST; // RULE7
      unit_nxt.snap_group    = 4'h0; // RULE8
      unit_nxt.snap_interval = srg_pkg::INTERVAL_RST; // RULE8
      snap_wr_nxt    = 3'h0; // RULE8
      snap_rd_nxt    = 3'h0; // RULE8
      ser_shift_nxt  = srg_pkg::SHIFT_RST; // RULE9
      ser_words_nxt  = srg_pkg::WORDS_RST; // RULE9
      ser_sync_nxt   = srg_pkg::SYNC_RST; // RULE9
      ser_div_nxt    = srg_pkg::SERDIV_RST; // RULE9
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      interp_cnt_r <= 4'h0;
      disc_rd_r    <= 4'h0;
      disc_wr_r    <= 4'h0;
      disc_coef_r  <= 6'h00;
      cordic_cnt_r <= 5'h00;
      fifo_dec_r   <= 2'h0;
      snap_wr_r    <= 3'h0;
      snap_rd_r    <= 3'h0;
      ser_shift_r  <= srg_pkg::SHIFT_RST;
      ser_words_r  <= srg_pkg::WORDS_RST;
      ser_sync_r   <= srg_pkg::SYNC_RST;
      ser_div_r    <= srg_pkg::SERDIV_RST;
      unit_r       <= '{ofifo_rd: srg_pkg::OFIFO_RD_RST, ofifo_wr: srg_pkg::OFIFO_WR_RST,
                        fifo_empty: 1'b1, fifo_full: 1'b0, fifo_depth: 4'h0, fifo_rd_strobe: 1'b0,
                        irq: 1'b0, snap_group: 4'h0, snap_interval: srg_pkg::INTERVAL_RST};
    end else begin
      interp_cnt_r <= interp_cnt_nxt;
      disc_rd_r    <= disc_rd_nxt;
      disc_wr_r    <= disc_wr_nxt;
      disc_coef_r  <= disc_coef_nxt;
      cordic_cnt_r <= cordic_cnt_nxt;
      fifo_dec_r   <= fifo_dec_nxt;
      snap_wr_r    <= snap_wr_nxt;
      snap_rd_r    <= snap_rd_nxt;
      ser_shift_r  <= ser_shift_nxt;
      ser_words_r  <= ser_words_nxt;
      ser_sync_r   <= ser_sync_nxt;
      ser_div_r    <= ser_div_nxt;
      unit_r       <= unit_nxt;
    end
  end

  assign unit_state = unit_r;
endmodule

// ---- tb/srg_host.sv ----
// Host model issuing APB control word transfers
`timescale 1ns/1ps
module srg_host (
  input wire logic        ref_clk,
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic [7:0]      paddr,
  output logic [31:0]     pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released bus must not show stale values
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ---- tb/srg_monitor.sv ----
// Checker for reset pulse widths and gain load behaviour
`timescale 1ns/1ps
module srg_monitor #(
  parameter int FE_CYC = 1,
  parameter int BE_CYC = 10
) (
  input wire logic                      ref_clk,
  input wire logic                      rst_n,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [7:0]                paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic [srg_pkg::ACC_W-1:0] limiter_out,
  input wire logic                      fe_reset_pulse,
  input wire logic                      be_reset_pulse,
  input wire logic                      timing_nco_fb_clear,
  input wire logic                      gain_load_strobe,
  input wire logic [srg_pkg::ACC_W-1:0] agc_accum,
  input wire srg_pkg::srg_gain_t        agc_gain,
  input wire srg_pkg::srg_unit_t        unit_state
);
  logic       wr_rst;
  logic       wr_g;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       cfg_r;
  logic       cfg_nxt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  assign wr_rst = psel && penable && pwrite && pready && paddr == srg_pkg::ADDR_SOFT_RESET;
  assign wr_g = psel && penable && pwrite && pready && paddr == srg_pkg::ADDR_GAIN_LOAD;
  // Saturating age of the last reset write
  always_comb begin
    cnt_nxt = (cnt_r > 8'(BE_CYC)) ? cnt_r : cnt_r + 8'h01;
    cfg_nxt = cfg_r;
    if (wr_rst)
      cnt_nxt = 8'h01;
    if (psel && penable && pwrite && pready && paddr == srg_pkg::ADDR_TEST_CFG)
      cfg_nxt = pwdata[srg_pkg::TEST_NCO_CLR_BIT];
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'(BE_CYC + 1);
      cfg_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      cfg_r <= cfg_nxt;
    end
  end
  property p_fields;
    logic [31:0] d;
    (wr_g, d = pwdata) |=> agc_gain == {d[15:12], 1'b1, d[11:5]};
  endproperty
  property p_load;
    logic [31:0] d;
    (wr_g, d = pwdata) |=> ##1 agc_accum == {d[15:5], 21'h0};
  endproperty
  a_fe_single: assert property (wr_rst |=> fe_reset_pulse ##1 !fe_reset_pulse)
    else $error("front-end pulse not one cycle");
  a_be_width: assert property (be_reset_pulse == (cnt_r <= 8'(BE_CYC)))
    else $error("back-end pulse width wrong");
  a_nco_gate: assert property (timing_nco_fb_clear == (be_reset_pulse && cfg_r))
    else $error("nco feedback clear gating wrong");
  a_gain_strobe: assert property (wr_g |=> gain_load_strobe ##1 !gain_load_strobe)
    else $error("gain load strobe wrong");
  a_gain_fields: assert property (p_fields)
    else $error("gain exponent or mantissa wrong");
  a_accum_load: assert property (p_load)
    else $error("accumulator load value wrong");
  a_accum_track: assert property (!gain_load_strobe |=> agc_accum == $past(limiter_out))
    else $error("accumulator not following limiter");
  a_unit_reset: assert property (be_reset_pulse && $past(be_reset_pulse) |->
    unit_state == {srg_pkg::OFIFO_RD_RST, srg_pkg::OFIFO_WR_RST, 12'h800, srg_pkg::INTERVAL_RST})
    else $error("unit state not at reset values");
  a_bus_no_error: assert property (pready && !pslverr)
    else $error("bus answer not ready or flagged error");
  c_nco: cover property (timing_nco_fb_clear);
  c_load: cover property (gain_load_strobe);
  c_both: cover property (fe_reset_pulse && be_reset_pulse);
endmodule

bind srg_top srg_monitor #(.FE_CYC(FE_CYC), .BE_CYC(BE_CYC)) mon_u (.ref_clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .limiter_out, .fe_reset_pulse, .be_reset_pulse,
  .timing_nco_fb_clear, .gain_load_strobe, .agc_accum, .agc_gain, .unit_state);

// ---- tb/tb_top.sv ----
// Testbench for soft reset pulses and gain load
`timescale 1ns/1ps
module tb_top;
  localparam int BE = 10;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, fe, be, clr, stb;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, limiter_out, agc_accum, rnd, d, r, lim_q;
  srg_pkg::srg_gain_t agc_gain;
  int err_count, n_compared, n_fe, n_be, n_clr, cyc;
  srg_top #(.FE_CYC(1), .BE_CYC(BE)) dut_u (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .limiter_out, .fe_reset_pulse(fe), .be_reset_pulse(be),
    .timing_nco_fb_clear(clr), .gain_load_strobe(stb), .agc_accum, .agc_gain, .unit_state());
  srg_host host_u (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Counting on the falling edge keeps clear and count apart
  always @(negedge ref_clk) begin
    n_fe += (fe === 1'b1);
    n_be += (be === 1'b1);
    n_clr += (clr === 1'b1);
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end
  always @(posedge ref_clk)
    limiter_out <= xs(limiter_out);
  initial begin
    rst_n = 1'b0;
    limiter_out = 32'hFEC7;
    rnd = 32'hFEC7;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    host_u.xfer(1'b0, srg_pkg::ADDR_TEST_CFG, rnd, r);
    chk(r, srg_pkg::TEST_CFG_RST);
    host_u.xfer(1'b1, 8'h20, 32'hFFFF_FFFF, r);
    host_u.xfer(1'b0, 8'h20, 32'h0, r);
    chk(r, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = {11'h0, i[0], 20'h0};
      host_u.xfer(1'b1, srg_pkg::ADDR_TEST_CFG, d, r);
      host_u.xfer(1'b0, srg_pkg::ADDR_TEST_CFG, 32'h0, r);
      chk(r, d);
      n_fe = 0;
      n_be = 0;
      n_clr = 0;
      rnd = xs(rnd);
      host_u.xfer(1'b1, srg_pkg::ADDR_SOFT_RESET, rnd, r);
      if (i[1])
        host_u.xfer(1'b1, srg_pkg::ADDR_SOFT_RESET, ~rnd, r);
      repeat (BE + 4) @(negedge ref_clk);
      chk(32'(n_fe), i[1] ? 32'd2 : 32'd1);
      chk(32'(n_be), 32'(BE + (i[1] ? 3 : 0)));
      chk(32'(n_clr), i[0] ? 32'(BE + (i[1] ? 3 : 0)) : 32'd0);
    end
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_001F : rnd;
      host_u.xfer(1'b1, srg_pkg::ADDR_GAIN_LOAD, d, r);
      @(negedge ref_clk);
      chk(32'(stb), 32'd1);
      chk(32'(agc_gain), {20'h0, d[15:12], 1'b1, d[11:5]});
      @(negedge ref_clk);
      chk(32'(stb), 32'd0);
      chk(agc_accum, {d[15:5], 21'h0});
      lim_q = limiter_out;
      @(negedge ref_clk);
      chk(agc_accum, lim_q);
    end
    host_u.xfer(1'b0, srg_pkg::ADDR_GAIN_LOAD, 32'h0, r);
    chk(r, 32'h0);
    end_sim();
  end
endmodule
